// ### dsz_or_exec.sv
//------------------------------------------------------------------------------
// Purpose: Executes decrement_skip_zero, or_literal_into_accumulator and
//          or_accumulator_with_file for a small 8-bit core.
// Assumes: Fetch offers one word a cycle with a valid flag on the same clock,
//          and the file memory returns the data at the word's low five bits in
//          the same cycle, without delay.
// Notes:   All outputs are registered, so results appear one edge after the
//          word is taken; other opcodes retire with no effect here.
//------------------------------------------------------------------------------
`timescale 1ns/1ps

module dsz_or_exec
  import dsz_or_pkg::*;
(
  input wire logic i_clk, // Core instruction clock, 100 MHz.
  input wire logic i_resetn, // Asynchronous reset, active low.
  input wire logic i_instr_valid, // A fetched word is offered this cycle.
  input wire logic [INSTR_W-1:0] i_instr, // The fetched word.
  input wire logic [DATA_W-1:0] i_file_rdata, // File contents at the word's address.
  output logic [DATA_W-1:0] o_accum, // Accumulator.
  output logic o_zero, // Zero flag.
  output logic o_file_we, // One-cycle file write strobe.
  output logic [ADDR_W-1:0] o_file_addr, // File write address.
  output logic [DATA_W-1:0] o_file_wdata, // File write data.
  output logic o_skip, // Pulse: prefetched word will be discarded.
  output logic o_nop_slot, // Pulse: a discarded word retired as no_operation.
  output logic o_retired // Pulse: an executed word retired.
);

  //----------------------------------------------------------------------------
  // Helper functions
  //----------------------------------------------------------------------------

  // Masked opcode compare, shared by all three decoders.
  function automatic logic op_match(input logic [INSTR_W-1:0] word,
                                    input logic [INSTR_W-1:0] mask,
                                    input logic [INSTR_W-1:0] pattern);
    op_match = (word & mask) == pattern;
  endfunction : op_match

  // All-zero test, used for the zero flag and for the skip decision.
  function automatic logic is_zero(input logic [DATA_W-1:0] value);
    is_zero = value == DATA_ZERO;
  endfunction : is_zero

  //----------------------------------------------------------------------------
  // Decode
  //----------------------------------------------------------------------------
  logic dec_dsz;
  logic dec_orl;
  logic dec_orf;
  logic dest_file;
  logic [ADDR_W-1:0] f_addr;
  logic [DATA_W-1:0] literal;
  logic [DATA_W-1:0] dec_result;
  logic [DATA_W-1:0] orl_result;
  logic [DATA_W-1:0] orf_result;

  // Field extraction and the three candidate results.
  assign dec_dsz = op_match(i_instr, MASK_FILE_OP, PAT_DECREMENT_SKIP_ZERO);
  assign dec_orl = op_match(i_instr, MASK_LIT_OP, PAT_OR_LITERAL_INTO_ACCUMULATOR);
  assign dec_orf = op_match(i_instr, MASK_FILE_OP, PAT_OR_ACCUMULATOR_WITH_FILE);
  assign dest_file = i_instr[DEST_BIT] != DEST_ACCUM;
  assign f_addr = i_instr[ADDR_LSB +: ADDR_W];
  assign literal = i_instr[LIT_LSB +: DATA_W];
  assign dec_result = i_file_rdata - DATA_ONE;
  assign orl_result = o_accum | literal;
  assign orf_result = o_accum | i_file_rdata;

  //----------------------------------------------------------------------------
  // Execute state
  //----------------------------------------------------------------------------
  exec_state_t state_reg;
  exec_state_t state_next;
  logic [DATA_W-1:0] accum_reg;
  logic [DATA_W-1:0] accum_next;
  logic zero_reg;
  logic zero_next;
  file_write_t fw_reg;
  file_write_t fw_next;
  logic skip_reg;
  logic skip_next;
  logic nop_reg;
  logic nop_next;
  logic retired_reg;
  logic retired_next;

  // Next-state logic. In ST_SQUASH the next offered word is already fetched and
  // must not act, so it is swallowed whole; this is why the skip costs a cycle.
  always_comb begin
    state_next = state_reg;
    accum_next = accum_reg;
    zero_next = zero_reg;
    fw_next = '{we: 1'b0, addr: fw_reg.addr, data: fw_reg.data};
    skip_next = 1'b0;
    nop_next = 1'b0;
    retired_next = 1'b0;
    unique case (state_reg)
      ST_SQUASH: begin
        if (i_instr_valid) begin
          nop_next = 1'b1;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_instr_valid) begin
          retired_next = 1'b1;
          if (dec_dsz) begin
            // Flags are left alone on purpose.
            if (dest_file) begin
              fw_next = '{we: 1'b1, addr: f_addr, data: dec_result};
            end else begin
              accum_next = dec_result;
            end
            if (is_zero(dec_result)) begin
              skip_next = 1'b1;
              state_next = ST_SQUASH;
            end
          end else if (dec_orl) begin
            accum_next = orl_result;
            zero_next = is_zero(orl_result);
          end else if (dec_orf) begin
            if (dest_file) begin
              fw_next = '{we: 1'b1, addr: f_addr, data: orf_result};
            end else begin
              accum_next = orf_result;
            end
            zero_next = is_zero(orf_result);
          end
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // Registers only; every output below is one of these flops.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_RUN;
      accum_reg <= ACCUM_RESET;
      zero_reg <= 1'b0;
      fw_reg <= '{we: 1'b0, addr: ADDR_RESET, data: DATA_ZERO};
      skip_reg <= 1'b0;
      nop_reg <= 1'b0;
      retired_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      accum_reg <= accum_next;
      zero_reg <= zero_next;
      fw_reg <= fw_next;
      skip_reg <= skip_next;
      nop_reg <= nop_next;
      retired_reg <= retired_next;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign o_accum = accum_reg;
  assign o_zero = zero_reg;
  assign o_file_we = fw_reg.we;
  assign o_file_addr = fw_reg.addr;
  assign o_file_wdata = fw_reg.data;
  assign o_skip = skip_reg;
  assign o_nop_slot = nop_reg;
  assign o_retired = retired_reg;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  logic run_take;
  assign run_take = i_instr_valid && (state_reg == ST_RUN);

  sequence dsz_zero_taken;
    run_take && dec_dsz && (i_file_rdata == DATA_ONE);
  endsequence

  // The swallow step: a word offered while a skip is still owed. Gaps before it
  // are allowed, so the wait is carried by the state flop, not by a repetition.
  sequence squash_take;
    (state_reg == ST_SQUASH) && i_instr_valid;
  endsequence

  chk_skip_announced: assert property (@(posedge i_clk) disable iff (!i_resetn)
    dsz_zero_taken |=> o_skip && o_retired && (state_reg == ST_SQUASH))
    else $error("zero decrement did not announce a skip");

  chk_dsz_file_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    run_take && dec_dsz && dest_file |=> o_file_we && o_file_wdata == $past(i_file_rdata) - DATA_ONE
      && o_file_addr == $past(f_addr))
    else $error("decrement to file produced the wrong write");

  chk_dsz_accum_dest: assert property (@(posedge i_clk) disable iff (!i_resetn)
    run_take && dec_dsz && !dest_file |=> !o_file_we && o_accum == $past(i_file_rdata) - DATA_ONE)
    else $error("decrement to accumulator produced the wrong value");

  chk_skip_discards_word: assert property (@(posedge i_clk) disable iff (!i_resetn)
    squash_take |=> o_nop_slot && !o_retired && !o_skip && !o_file_we && $stable(o_accum) && $stable(o_zero))
    else $error("prefetched word after a zero decrement was not discarded");

  chk_no_skip_nonzero: assert property (@(posedge i_clk) disable iff (!i_resetn)
    run_take && dec_dsz && (i_file_rdata != DATA_ONE) |=> !o_skip ##1 !o_nop_slot)
    else $error("skip taken on a nonzero decrement result");

  chk_or_literal_value: assert property (@(posedge i_clk) disable iff (!i_resetn)
    run_take && dec_orl |=> o_accum == ($past(o_accum) | $past(literal)) && !o_file_we)
    else $error("literal OR gave the wrong accumulator");

  chk_or_file_dest: assert property (@(posedge i_clk) disable iff (!i_resetn)
    run_take && dec_orf && dest_file |=> o_file_we && o_file_wdata == ($past(o_accum) | $past(i_file_rdata))
      && $stable(o_accum))
    else $error("file OR with file destination misbehaved");

  chk_or_zero_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    run_take && (dec_orl || dec_orf) |=> o_zero == ((o_file_we ? o_file_wdata : o_accum) == DATA_ZERO))
    else $error("zero flag does not follow the OR result");

  chk_dsz_keeps_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    run_take && dec_dsz |=> $stable(o_zero))
    else $error("decrement changed the zero flag");

endmodule : dsz_or_exec

// ### dsz_or_file_model.sv
// Purpose: File register memory seen by the executor's read and write ports.
// Assumes: Register i starts at value i, so low addresses reach zero quickly.
// Notes:   Forwards a pending write so back-to-back words see fresh data.
`timescale 1ns/1ps

module dsz_or_file_model
  import dsz_or_pkg::*;
(
  input wire logic i_clk, // Core clock.
  input wire logic i_instr_valid, // Fetch offers a word.
  input wire logic [INSTR_W-1:0] i_instr, // Offered word, low bits address.
  input wire logic i_file_we, // Write strobe from the executor.
  input wire logic [ADDR_W-1:0] i_file_addr, // Write address.
  input wire logic [DATA_W-1:0] i_file_wdata, // Write data.
  output logic [DATA_W-1:0] o_rdata // Read data for the offered word.
);
  logic [DATA_W-1:0] mem [32];
  logic [DATA_W-1:0] fwd;

  // Writes land at the edge after the strobe is seen.
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = i[DATA_W-1:0];
  end
  always @(posedge i_clk) begin
    if (i_file_we === 1'b1) mem[i_file_addr] <= i_file_wdata;
  end

  // Without a valid word the port is not read, so it shows the bitwise inverse of the addressed data.
  always_comb begin
    fwd = (i_file_we && i_file_addr == i_instr[4:0]) ? i_file_wdata : mem[i_instr[4:0]];
    o_rdata = i_instr_valid ? fwd : ~fwd;
  end
endmodule : dsz_or_file_model

// ### dsz_or_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Shared constants and types for the decrement-skip and OR executor.
// Assumes: 12-bit instruction words and an 8-bit datapath with 32 file registers.
// Notes:   Opcode patterns are matched under a mask; x bits of a pattern are zero.
//------------------------------------------------------------------------------
package dsz_or_pkg;

  //----------------------------------------------------------------------------
  // Widths and field positions
  //----------------------------------------------------------------------------
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int DEST_BIT = 5;
  localparam int LIT_LSB = 0;
  localparam int ADDR_LSB = 0;

  //----------------------------------------------------------------------------
  // Opcode masks and patterns
  //----------------------------------------------------------------------------
  localparam logic [INSTR_W-1:0] MASK_FILE_OP = 12'h0fc0;
  localparam logic [INSTR_W-1:0] MASK_LIT_OP = 12'h0f00;
  localparam logic [INSTR_W-1:0] PAT_DECREMENT_SKIP_ZERO = 12'h02c0;
  localparam logic [INSTR_W-1:0] PAT_OR_LITERAL_INTO_ACCUMULATOR = 12'h0d00;
  localparam logic [INSTR_W-1:0] PAT_OR_ACCUMULATOR_WITH_FILE = 12'h0100;

  //----------------------------------------------------------------------------
  // Reset values and arithmetic constants
  //----------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
  localparam logic DEST_ACCUM = 1'b0;

  //----------------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SQUASH
  } exec_state_t;

  // One write toward the file register memory.
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_write_t;

endpackage : dsz_or_pkg

// ### tb_dsz_or_exec.sv
// Purpose: Self-checking bench for the decrement-skip and OR executor.
// Assumes: Inputs change on the falling edge; results are read one cycle later.
// Notes:   A mirror of accumulator, flag and file memory gives the expectations.
`timescale 1ns/1ps

module tb_dsz_or_exec;
  import dsz_or_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_instr_valid = 1'b0;
  logic [INSTR_W-1:0] i_instr = 12'h000;
  logic [DATA_W-1:0] i_file_rdata, o_accum, o_file_wdata, e_acc, ex_wd;
  logic [DATA_W-1:0] e_mem [32];
  logic [ADDR_W-1:0] o_file_addr, ex_addr;
  logic o_zero, o_file_we, o_skip, o_nop_slot, o_retired;
  logic e_z, pend, ex_ret, ex_nop, ex_we, ex_skip;
  logic [31:0] rs = 32'h0000_005f;
  int errors = 0;
  int n_checks = 0;

  always #5 i_clk = ~i_clk;

  dsz_or_exec uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_file_rdata(i_file_rdata), .o_accum(o_accum), .o_zero(o_zero),
    .o_file_we(o_file_we), .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata),
    .o_skip(o_skip), .o_nop_slot(o_nop_slot), .o_retired(o_retired));
  dsz_or_file_model mem_model (.i_clk(i_clk), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_file_we(o_file_we), .i_file_addr(o_file_addr), .i_file_wdata(o_file_wdata),
    .o_rdata(i_file_rdata));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte

  // Checks the previous word's results, then offers the next word and predicts it.
  task automatic step(input logic v, input logic [INSTR_W-1:0] w);
    logic [DATA_W-1:0] f, r;
    @(negedge i_clk);
    chk_bit("retired", ex_ret, o_retired);
    chk_bit("nop_slot", ex_nop, o_nop_slot);
    chk_bit("skip", ex_skip, o_skip);
    chk_bit("file_we", ex_we, o_file_we);
    chk_byte("accum", e_acc, o_accum);
    chk_bit("zero", e_z, o_zero);
    if (ex_we) begin
      chk_byte("file_addr", {3'h0, ex_addr}, {3'h0, o_file_addr});
      chk_byte("file_wdata", ex_wd, o_file_wdata);
    end
    i_instr_valid <= v;
    i_instr <= w;
    {ex_ret, ex_nop, ex_we, ex_skip} = 4'h0;
    ex_addr = w[4:0];
    f = e_mem[w[4:0]];
    r = f;
    if (v && pend) begin
      ex_nop = 1'b1;
      pend = 1'b0;
    end else if (v) begin
      ex_ret = 1'b1;
      if ((w & MASK_FILE_OP) == PAT_DECREMENT_SKIP_ZERO) begin
        r = f - 8'h01;
        ex_skip = (r == 8'h00);
        pend = ex_skip;
      end else if ((w & MASK_LIT_OP) == PAT_OR_LITERAL_INTO_ACCUMULATOR) begin
        e_acc = e_acc | w[7:0];
        e_z = (e_acc == 8'h00);
      end else if ((w & MASK_FILE_OP) == PAT_OR_ACCUMULATOR_WITH_FILE) begin
        r = e_acc | f;
        e_z = (r == 8'h00);
      end else begin
        return;
      end
      if (((w & MASK_LIT_OP) != PAT_OR_LITERAL_INTO_ACCUMULATOR) && w[5]) begin
        ex_we = 1'b1;
        ex_wd = r;
        e_mem[w[4:0]] = r;
      end else if ((w & MASK_LIT_OP) != PAT_OR_LITERAL_INTO_ACCUMULATOR) begin
        e_acc = r;
      end
    end
  endtask : step

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Corner words first: zero OR, skip, swallowed word, wrap, then a random mix.
  initial begin
    logic [INSTR_W-1:0] corners [8] = '{12'hd00, 12'h2e1, 12'hdff, 12'h2c0, 12'h101,
      12'h2e2, 12'h123, 12'hd35};
    for (int i = 0; i < 32; i++) e_mem[i] = i[7:0];
    {e_acc, e_z, pend, ex_ret, ex_nop, ex_we, ex_skip} = '0;
    repeat (20) @(posedge i_clk);
    @(negedge i_clk) i_resetn <= 1'b1;
    foreach (corners[i]) step(1'b1, corners[i]);
    step(1'b1, 12'h2e2);
    step(1'b0, 12'hd00);
    step(1'b1, 12'hd01);
    for (int n = 0; n < 400; n++) begin
      rs = xorshift(rs);
      case (rs[1:0])
        2'd0: step(rs[22:20] != 3'h0, {6'h0b, rs[7:2]});
        2'd1: step(rs[22:20] != 3'h0, {4'hd, rs[15:8]});
        2'd2: step(rs[22:20] != 3'h0, {6'h04, rs[7:2]});
        default: step(rs[22:20] != 3'h0, rs[19:8]);
      endcase
    end
    step(1'b0, 12'h000);
    print_verdict();
  end

  // Watchdog well beyond the roughly 430 cycles the sequence needs.
  initial begin
    #50000;
    errors++;
    print_verdict();
  end
endmodule : tb_dsz_or_exec
